// file: slr_link_if.sv
// Link between upstream source end and sink end.
// Assumes both ends run on the same clock; no clocking block.
`timescale 1ns/100ps
`default_nettype none
interface slr_link_if import slr_pkg::*;;
	slr_lnk_s fwd;
	logic hot_plug;
	modport dev (input fwd, output hot_plug);
	modport host (output fwd, input hot_plug);
endinterface : slr_link_if
`default_nettype wire

// file: slr_link_monitor.sv
// Checker on the link and on the sink's bus and stream ports.
// Assumes the bench instantiates it beside the link, on ref_clk.
`timescale 1ns/100ps
`default_nettype none
module slr_link_monitor import slr_pkg::*;
(
	input wire logic ref_clk,
	input wire logic nrst,
	input wire slr_lnk_s fwd,
	input wire logic hot_plug,
	input wire logic wb_cyc,
	input wire logic wb_stb,
	input wire logic wb_ack,
	input wire logic vid_valid,
	input wire logic stream_attr_valid,
	input wire logic aud_tvalid,
	input wire logic [7:0] aud_tid
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!nrst);
	// Pulse width is 400 cycles, too long for a repetition
	logic [HPD_CW-1:0] hp_cnt_r;
	logic [HPD_CW-1:0] hp_cnt_nxt;
	always_comb hp_cnt_nxt = hot_plug ? hp_cnt_r + 1'b1 : '0;
	always_ff @(posedge ref_clk or negedge nrst)
	begin
		if (!nrst)
			hp_cnt_r <= '0;
		else
			hp_cnt_r <= hp_cnt_nxt;
	end
	////////////////
	a_replug_hpd: assert property ($rose(fwd.cable) |-> ##[1:2] hot_plug)
		else $error("no hot-plug after replug");
	a_hpd_len: assert property ($fell(hot_plug) |-> hp_cnt_r == HPD_CYC)
		else $error("hot-plug width wrong");
	a_hpd_max: assert property (hp_cnt_r <= HPD_CYC)
		else $error("hot-plug too long");
	a_unplug_quiet: assert property (!fwd.cable |=> !vid_valid && !aud_tvalid)
		else $error("data while unplugged");
	a_attr_invalid: assert property (!fwd.video_on |=> !stream_attr_valid)
		else $error("attributes valid without video");
	a_aud_source: assert property (aud_tvalid |-> $past(fwd.aud_valid))
		else $error("sample without cause");
	a_tid_chan: assert property (aud_tvalid |-> aud_tid[3:0] == {1'b0, $past(fwd.aud_ch)})
		else $error("channel id wrong");
	a_wb_answer: assert property (wb_cyc && wb_stb && !wb_ack |=> wb_ack)
		else $error("bus ack late");
	a_ack_pulse: assert property (wb_ack |=> !wb_ack)
		else $error("bus ack held");
endmodule : slr_link_monitor
`default_nettype wire

// file: slr_pkg.sv
// Constants, register map and link bundle of the sink link/event/audio block.
// Assumes one 200 MHz clock shared by both ends and by the register bus.
// Overview of operation
// - Training mode blocks data path, detects pattern
// - Controller sets training mode before pattern arrives
// - One, two or four pixels per clock
// - M and N outputs with change pulse for video M/N only
// - Video-absent event; attributes then invalid
// - Vertical-blank event when video resumes
// - Format-change event on mode change
// - Training-loss event on unplug or lost lock
// - Replug resets sink and raises hot-plug
// - Software raises hot-plug after training loss
// - Lane and PHY state readable
// - Buffer audio, stream samples, eight channels
// - Audio stream receiver never back-pressures
// - TID carries channel and stream identifiers
// - Drop samples of unallocated channels
// - Audio control 0 flushes, 1 enables
// - Status bit 0 flags info packet
// - Drop new packets while buffer unread
// - Status clears after packet buffer read
// - Maskable packet-received interrupts in cause register
// - System derives 512 fs clock from M/N
// - Software disables audio while mute set
package slr_pkg;

	localparam int CLK_PERIOD_NS = 5;
	localparam int HPD_PULSE_NS = 2000;
	localparam int HPD_CYC = (HPD_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int HPD_CW = 9;

	localparam int PIX_W = 48;
	localparam int PPC_MAX = 4;
	localparam int MN_W = 24;
	localparam int AUD_W = 32;
	localparam int PKT_WORDS = 8;
	localparam int CH_N = 8;
	localparam logic [2:0] PKT_LAST = 3'h7;

	////////////////////////////////////////////////////////////////
	localparam logic [7:0] REG_LINK_CTRL = 8'h00;
	localparam logic [7:0] REG_EVENT = 8'h04;
	localparam logic [7:0] REG_EV_MASK = 8'h08;
	localparam logic [7:0] REG_LANE_STATE = 8'h0C;
	localparam logic [7:0] REG_PHY_STATE = 8'h10;
	localparam logic [7:0] REG_AUD_CTRL = 8'h14;
	localparam logic [7:0] REG_AUD_STATUS = 8'h18;
	localparam logic [7:0] REG_AUD_M = 8'h1C;
	localparam logic [7:0] REG_AUD_N = 8'h20;
	localparam logic [7:0] REG_VID_M = 8'h24;
	localparam logic [7:0] REG_VID_N = 8'h28;
	localparam logic [7:0] REG_STREAM_ATTR = 8'h2C;
	localparam logic [7:0] REG_HOT_PLUG = 8'h30;
	localparam logic [2:0] PAGE_INFO = 3'h2;
	localparam logic [2:0] PAGE_EXT = 3'h3;

	localparam int CTRL_TRAIN_LSB = 0;
	localparam int CTRL_PPC_LSB = 2;
	localparam int AUD_EN_BIT = 0;
	localparam int STAT_INFO_BIT = 0;
	localparam int STAT_EXT_BIT = 1;
	localparam int PHY_PLL_BIT = 0;
	localparam int PHY_RST_BIT = 1;
	localparam int LANE_LOCK_LSB = 4;
	localparam int INFO_ALLOC_LSB = 8;
	localparam int INFO_SID_LSB = 16;

	localparam int EV_NOVID = 0;
	localparam int EV_VBLANK = 1;
	localparam int EV_MODE = 2;
	localparam int EV_TLOST = 3;
	localparam int EV_INFO = 4;
	localparam int EV_EXT = 5;
	localparam int EV_TDONE = 6;
	localparam int EV_N = 7;

	localparam logic [1:0] PPC_1 = 2'h0;
	localparam logic [1:0] PPC_2 = 2'h1;
	localparam logic [3:0] PIX_EN_1 = 4'h1;
	localparam logic [3:0] PIX_EN_2 = 4'h3;
	localparam logic [3:0] PIX_EN_4 = 4'hF;

	typedef enum logic [1:0] {SLR_TRAIN_OFF, SLR_TP1, SLR_TP2, SLR_TP3} slr_train_e;

	// Everything the upstream source places on the link
	typedef struct packed {
		logic cable;
		logic lock;
		logic [1:0] pattern;
		logic video_on;
		logic vid_valid;
		logic [PIX_W*PPC_MAX-1:0] pix;
		logic [7:0] mode;
		logic [MN_W-1:0] vid_m;
		logic [MN_W-1:0] vid_n;
		logic [MN_W-1:0] aud_m;
		logic [MN_W-1:0] aud_n;
		logic aud_valid;
		logic [2:0] aud_ch;
		logic [AUD_W-1:0] aud_data;
		logic pkt_valid;
		logic pkt_first;
		logic pkt_ext;
		logic [31:0] pkt_data;
	} slr_lnk_s;

endpackage : slr_pkg

// file: slr_sink.sv
// Sink end: training gate, M/N, link events, packets, audio stream, Wishbone registers.
// Assumes link and Phy_state_reg arrive on ref_clk; the audio stream sink never stalls.
`timescale 1ns/100ps
`default_nettype none
module slr_sink import slr_pkg::*;
(
	input wire logic ref_clk,
	input wire logic nrst,
	input wire logic ce,
	slr_link_if.dev l,
	input wire logic wb_cyc,
	input wire logic wb_stb,
	input wire logic wb_we,
	input wire logic [7:0] wb_adr,
	input wire logic [3:0] wb_sel,
	input wire logic [31:0] wb_dat_w,
	output logic [31:0] wb_dat_r,
	output logic wb_ack,
	input wire logic [3:0] phy_lane_align,
	input wire logic [3:0] phy_sym_lock,
	input wire logic phy_pll_lock,
	input wire logic phy_rst_done,
	output logic [PIX_W*PPC_MAX-1:0] vid_pixel,
	output logic [PPC_MAX-1:0] vid_pix_en,
	output logic vid_valid,
	output logic [7:0] stream_mode,
	output logic stream_attr_valid,
	output logic [MN_W-1:0] vid_m_value,
	output logic [MN_W-1:0] vid_n_value,
	output logic vid_mn_update,
	output logic [MN_W-1:0] audio_m_value,
	output logic [MN_W-1:0] audio_n_value,
	output logic aud_tvalid,
	output logic [AUD_W-1:0] aud_tdata,
	output logic [7:0] aud_tid,
	output logic irq
);

	typedef struct packed {
		logic ack;
		logic [31:0] dat;
		slr_train_e train;
		logic [1:0] ppc;
		logic [EV_N-1:0] ev;
		logic [EV_N-1:0] mask;
		logic irq;
		logic aud_en;
		logic info_full;
		logic ext_full;
		logic pkt_busy;
		logic pkt_ext;
		logic [2:0] pkt_idx;
		logic [PKT_WORDS-1:0][31:0] info;
		logic [PKT_WORDS-1:0][31:0] ext;
		logic [CH_N-1:0] alloc;
		logic [3:0] sid;
		logic cable_d;
		logic lock_d;
		logic video_d;
		logic [7:0] mode;
		logic msa_ok;
		logic [MN_W-1:0] vm;
		logic [MN_W-1:0] vn;
		logic mn_upd;
		logic [MN_W-1:0] am;
		logic [MN_W-1:0] an;
		logic [PIX_W*PPC_MAX-1:0] pix;
		logic [PPC_MAX-1:0] pix_en;
		logic vvalid;
		logic tvalid;
		logic [AUD_W-1:0] tdata;
		logic [7:0] tid;
		logic hot_plug_signal;
		logic [HPD_CW-1:0] hpd_cnt;
	} slr_dev_s;

	slr_dev_s s_r;
	slr_dev_s s_nxt;
	slr_lnk_s f;
	logic [31:0] wm;
	logic acc;
	logic wr;
	logic rd;
	logic blk;
	logic flush;
	logic take;
	logic [2:0] widx;
	logic [EV_N-1:0] ev_set;
	logic [EV_N-1:0] ev_clr;

	assign f = l.fwd;

	////////////////////////////////////////////////////////////////
	always_comb
	begin
		s_nxt = s_r;
		ev_set = '0;
		ev_clr = '0;
		flush = 1'b0;
		take = 1'b0;
		widx = 3'h0;
		wm = {{8{wb_sel[3]}}, {8{wb_sel[2]}}, {8{wb_sel[1]}}, {8{wb_sel[0]}}};
		acc = wb_cyc & wb_stb & ~s_r.ack;
		wr = acc & wb_we;
		rd = acc & ~wb_we;
		s_nxt.ack = acc;
		s_nxt.dat = '0;

		// Register reads
		if (rd)
		begin
			case (wb_adr)
				REG_LINK_CTRL:
				begin
					s_nxt.dat[CTRL_TRAIN_LSB +: 2] = s_r.train;
					s_nxt.dat[CTRL_PPC_LSB +: 2] = s_r.ppc;
				end
				REG_EVENT: s_nxt.dat[EV_N-1:0] = s_r.ev;
				REG_EV_MASK: s_nxt.dat[EV_N-1:0] = s_r.mask;
				REG_LANE_STATE:
				begin
					s_nxt.dat[3:0] = phy_lane_align;
					s_nxt.dat[LANE_LOCK_LSB +: 4] = phy_sym_lock;
				end
				REG_PHY_STATE:
				begin
					s_nxt.dat[PHY_PLL_BIT] = phy_pll_lock;
					s_nxt.dat[PHY_RST_BIT] = phy_rst_done;
				end
				REG_AUD_CTRL: s_nxt.dat[AUD_EN_BIT] = s_r.aud_en;
				REG_AUD_STATUS:
				begin
					s_nxt.dat[STAT_INFO_BIT] = s_r.info_full;
					s_nxt.dat[STAT_EXT_BIT] = s_r.ext_full;
				end
				REG_AUD_M: s_nxt.dat[MN_W-1:0] = s_r.am;
				REG_AUD_N: s_nxt.dat[MN_W-1:0] = s_r.an;
				REG_VID_M: s_nxt.dat[MN_W-1:0] = s_r.vm;
				REG_VID_N: s_nxt.dat[MN_W-1:0] = s_r.vn;
				REG_STREAM_ATTR: s_nxt.dat[7:0] = s_r.mode;
				default:
				begin
					if (wb_adr[7:5] == PAGE_INFO)
					begin
						s_nxt.dat = s_r.info[wb_adr[4:2]];
						if (wb_adr[4:2] == PKT_LAST)
							s_nxt.info_full = 1'b0;
					end
					else if (wb_adr[7:5] == PAGE_EXT)
					begin
						s_nxt.dat = s_r.ext[wb_adr[4:2]];
						if (wb_adr[4:2] == PKT_LAST)
							s_nxt.ext_full = 1'b0;
					end
				end
			endcase
		end

		// Register writes; unmapped offsets are acknowledged and ignored
		if (wr)
		begin
			case (wb_adr)
				REG_LINK_CTRL:
				begin
					if (wb_sel[0])
					begin
						s_nxt.train = slr_train_e'(wb_dat_w[CTRL_TRAIN_LSB +: 2]);
						s_nxt.ppc = wb_dat_w[CTRL_PPC_LSB +: 2];
					end
				end
				REG_EVENT: ev_clr = wb_dat_w[EV_N-1:0] & wm[EV_N-1:0];
				REG_EV_MASK: s_nxt.mask = (s_r.mask & ~wm[EV_N-1:0]) | (wb_dat_w[EV_N-1:0] & wm[EV_N-1:0]);
				REG_AUD_CTRL:
				begin
					if (wb_sel[0])
					begin
						s_nxt.aud_en = wb_dat_w[AUD_EN_BIT];
						flush = ~wb_dat_w[AUD_EN_BIT];
					end
				end
				REG_HOT_PLUG:
				begin
					if (wb_sel[0] & wb_dat_w[0])
					begin
						s_nxt.hot_plug_signal = 1'b1;
						s_nxt.hpd_cnt = HPD_CW'(HPD_CYC - 1);
					end
				end
				default: ;
			endcase
		end

		////////////////////////////////////////////////////////////////
		// Link events
		s_nxt.cable_d = f.cable;
		s_nxt.lock_d = f.lock;
		s_nxt.video_d = f.video_on;
		s_nxt.mode = f.mode;
		if (s_r.video_d & ~f.video_on)
			ev_set[EV_NOVID] = 1'b1;
		if (~s_r.video_d & f.video_on)
			ev_set[EV_VBLANK] = 1'b1;
		if (s_r.video_d & f.video_on & (f.mode != s_r.mode))
			ev_set[EV_MODE] = 1'b1;
		if ((s_r.cable_d & ~f.cable) | (s_r.lock_d & ~f.lock & f.cable))
			ev_set[EV_TLOST] = 1'b1;
		if ((s_r.train != SLR_TRAIN_OFF) & (f.pattern == s_r.train))
			ev_set[EV_TDONE] = 1'b1;
		s_nxt.msa_ok = f.video_on & f.cable & f.lock;

		// Replug: back to idle state and a hot-plug pulse, no software needed
		if (~s_r.cable_d & f.cable)
		begin
			s_nxt.train = SLR_TRAIN_OFF;
			flush = 1'b1;
			s_nxt.hot_plug_signal = 1'b1;
			s_nxt.hpd_cnt = HPD_CW'(HPD_CYC - 1);
		end
		else if (s_r.hot_plug_signal)
		begin
			if (s_r.hpd_cnt == '0)
				s_nxt.hot_plug_signal = 1'b0;
			else
				s_nxt.hpd_cnt = s_r.hpd_cnt - 1'b1;
		end

		// M and N follow the link, with a pulse on any video M or N change
		s_nxt.vm = f.vid_m;
		s_nxt.vn = f.vid_n;
		s_nxt.mn_upd = (f.vid_m != s_r.vm) | (f.vid_n != s_r.vn);
		s_nxt.am = f.aud_m;
		s_nxt.an = f.aud_n;

		// Functional data path, held off while training
		blk = (s_r.train != SLR_TRAIN_OFF) | ~f.cable;
		s_nxt.vvalid = f.vid_valid & f.video_on & ~blk;
		s_nxt.pix = f.pix;
		unique case (s_r.ppc)
			PPC_1: s_nxt.pix_en = PIX_EN_1;
			PPC_2: s_nxt.pix_en = PIX_EN_2;
			default: s_nxt.pix_en = PIX_EN_4;
		endcase

		// Audio: one registered stage, no stall input by design
		s_nxt.tvalid = f.aud_valid & s_r.aud_en & ~blk & s_r.alloc[f.aud_ch] & ~flush;
		s_nxt.tdata = f.aud_data;
		s_nxt.tid = {s_r.sid, 1'b0, f.aud_ch};

		////////////////////////////////////////////////////////////////
		// Info/extension packet capture
		if (flush)
		begin
			s_nxt.info_full = 1'b0;
			s_nxt.ext_full = 1'b0;
			s_nxt.pkt_busy = 1'b0;
		end
		else if (f.pkt_valid & ~blk)
		begin
			if (f.pkt_first)
			begin
				take = ~(f.pkt_ext ? s_r.ext_full : s_r.info_full);
				s_nxt.pkt_ext = f.pkt_ext;
				s_nxt.pkt_busy = take;
			end
			else
			begin
				take = s_r.pkt_busy;
				widx = s_r.pkt_idx;
			end
			if (take)
			begin
				if (s_nxt.pkt_ext)
					s_nxt.ext[widx] = f.pkt_data;
				else
					s_nxt.info[widx] = f.pkt_data;
				s_nxt.pkt_idx = widx + 3'h1;
				if (widx == PKT_LAST)
				begin
					s_nxt.pkt_busy = 1'b0;
					if (s_nxt.pkt_ext)
					begin
						s_nxt.ext_full = 1'b1;
						ev_set[EV_EXT] = 1'b1;
					end
					else
					begin
						s_nxt.info_full = 1'b1;
						ev_set[EV_INFO] = 1'b1;
						s_nxt.alloc = s_r.info[0][INFO_ALLOC_LSB +: CH_N];
						s_nxt.sid = s_r.info[0][INFO_SID_LSB +: 4];
					end
				end
			end
		end

		// A new event outranks a clear in the same cycle
		s_nxt.ev = (s_r.ev & ~ev_clr) | ev_set;
		s_nxt.irq = |(s_nxt.ev & s_nxt.mask);
	end

	always_ff @(posedge ref_clk or negedge nrst)
	begin
		if (!nrst)
			s_r <= '0;
		else if (ce)
			s_r <= s_nxt;
	end

	////////////////////////////////////////////////////////////////
	assign l.hot_plug = s_r.hot_plug_signal;
	assign wb_ack = s_r.ack;
	assign wb_dat_r = s_r.dat;
	assign vid_pixel = s_r.pix;
	assign vid_pix_en = s_r.pix_en;
	assign vid_valid = s_r.vvalid;
	assign stream_mode = s_r.mode;
	assign stream_attr_valid = s_r.msa_ok;
	assign vid_m_value = s_r.vm;
	assign vid_n_value = s_r.vn;
	assign vid_mn_update = s_r.mn_upd;
	assign audio_m_value = s_r.am;
	assign audio_n_value = s_r.an;
	assign aud_tvalid = s_r.tvalid;
	assign aud_tdata = s_r.tdata;
	assign aud_tid = s_r.tid;
	assign irq = s_r.irq;

endmodule : slr_sink
`default_nettype wire

// file: slr_source.sv
// Upstream end: registers the user's link bundle onto the link and reports hot-plug.
// Assumes the user side runs on ref_clk and sets the sink's training mode first.
`timescale 1ns/100ps
`default_nettype none
module slr_source import slr_pkg::*;
(
	input wire logic ref_clk,
	input wire logic nrst,
	input wire logic ce,
	slr_link_if.host l,
	input wire slr_lnk_s u_fwd,
	output logic retrain_req
);

	typedef struct packed {
		slr_lnk_s fwd;
		logic hp_d;
		logic retrain;
	} slr_src_s;

	slr_src_s s_r;
	slr_src_s s_nxt;

	always_comb
	begin
		s_nxt = s_r;
		s_nxt.fwd = u_fwd;
		s_nxt.hp_d = l.hot_plug;
		// Hot-plug rising edge asks the user side to retrain
		s_nxt.retrain = l.hot_plug & ~s_r.hp_d;
	end

	always_ff @(posedge ref_clk or negedge nrst)
	begin
		if (!nrst)
			s_r <= '0;
		else if (ce)
			s_r <= s_nxt;
	end

	assign l.fwd = s_r.fwd;
	assign retrain_req = s_r.retrain;

endmodule : slr_source
`default_nettype wire

// file: test_sink_link_events_audio_rx.sv
// Bench joining source and sink ends over the link.
// Assumes the 200 MHz clock; the run ends in conclude.
`timescale 1ns/100ps
`default_nettype none
module test_sink_link_events_audio_rx import slr_pkg::*;;
	logic ref_clk = 1'b0;
	logic nrst = 1'b0;
	logic wb_cyc = 1'b0, wb_stb = 1'b0, wb_we = 1'b0;
	logic [7:0] wb_adr = 8'h00;
	logic [3:0] wb_sel = 4'h0;
	logic [31:0] wb_dat_w = 32'h0000_0000;
	logic [3:0] phy_lane_align = 4'h3, phy_sym_lock = 4'h5;
	logic phy_pll_lock = 1'b1, phy_rst_done = 1'b1;
	slr_lnk_s u_fwd = '0;
	logic [PIX_W*PPC_MAX-1:0] vid_pixel;
	logic [PPC_MAX-1:0] vid_pix_en;
	logic wb_ack, vid_valid, vid_mn_update, stream_attr_valid, aud_tvalid, irq, retrain_req;
	logic [7:0] stream_mode, aud_tid;
	logic [MN_W-1:0] vid_m_value, vid_n_value, audio_m_value, audio_n_value;
	logic [31:0] wb_dat_r, aud_tdata, rd;
	logic [39:0] aq[$];
	int err_count = 0, cmp_count = 0, mn_cnt = 0, rr_cnt = 0, n0;
	always #2.5 ref_clk = ~ref_clk;
	////////////////
	slr_link_if u_slr_link_if ();
	slr_source u_slr_source (.ref_clk, .nrst, .ce(1'b1), .l(u_slr_link_if), .u_fwd, .retrain_req);
	slr_sink u_slr_sink (.ref_clk, .nrst, .ce(1'b1), .l(u_slr_link_if), .wb_cyc, .wb_stb, .wb_we,
		.wb_adr, .wb_sel, .wb_dat_w, .wb_dat_r, .wb_ack, .phy_lane_align, .phy_sym_lock, .phy_pll_lock,
		.phy_rst_done, .vid_pixel, .vid_pix_en, .vid_valid, .stream_mode, .stream_attr_valid, .vid_m_value,
		.vid_n_value, .vid_mn_update, .audio_m_value, .audio_n_value, .aud_tvalid, .aud_tdata, .aud_tid, .irq);
	slr_link_monitor u_slr_link_monitor (.ref_clk, .nrst, .fwd(u_slr_link_if.fwd),
		.hot_plug(u_slr_link_if.hot_plug), .wb_cyc, .wb_stb, .wb_ack, .vid_valid, .stream_attr_valid,
		.aud_tvalid, .aud_tid);
	// The stream never stalls, so every valid cycle is one sample
	always @(posedge ref_clk)
	begin
		if (aud_tvalid === 1'b1)
			aq.push_back({aud_tid, aud_tdata});
		if (vid_mn_update === 1'b1)
			mn_cnt++;
		if (retrain_req === 1'b1)
			rr_cnt++;
	end
	////////////////
	task automatic conclude();
		$display("mismatches %0d checks %0d", err_count, cmp_count);
		if (err_count == 0 && cmp_count > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : conclude
	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		cmp_count++;
		if (got !== exp)
		begin
			err_count++;
			$display("CHECK FAILED %s exp %h got %h", nm, exp, got);
		end
	endtask : chk
	task automatic cyc(input int n);
		repeat (n) @(posedge ref_clk);
	endtask : cyc
	// Entered just after an edge; holds the request until ack is sampled
	task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
		wb_cyc <= 1'b1;
		wb_stb <= 1'b1;
		wb_we <= we;
		wb_adr <= a;
		wb_sel <= 4'hF;
		wb_dat_w <= d;
		do
			@(posedge ref_clk);
		while (wb_ack !== 1'b1);
		rd = wb_dat_r;
		wb_cyc <= 1'b0;
		wb_stb <= 1'b0;
		@(posedge ref_clk);
	endtask : wb
	task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
		wb(1'b0, a, 32'h0000_0000);
		chk(nm, e, rd & m);
	endtask : rdc
	task automatic pkt(input logic ext, input logic [31:0] w0);
		for (int i = 0; i < PKT_WORDS; i++)
		begin
			u_fwd.pkt_valid <= 1'b1;
			u_fwd.pkt_first <= (i == 0);
			u_fwd.pkt_ext <= ext;
			u_fwd.pkt_data <= w0 + 32'(i);
			@(posedge ref_clk);
		end
		u_fwd.pkt_valid <= 1'b0;
		cyc(4);
	endtask : pkt
	task automatic snd();
		aq.delete();
		for (int c = 0; c < CH_N; c++)
		begin
			u_fwd.aud_valid <= 1'b1;
			u_fwd.aud_ch <= 3'(c);
			u_fwd.aud_data <= 32'h0000_1000 + 32'(c);
			@(posedge ref_clk);
		end
		u_fwd.aud_valid <= 1'b0;
		cyc(4);
	endtask : snd
	////////////////
	initial
	begin
		repeat (20000) @(posedge ref_clk);
		err_count++;
		conclude();
	end
	initial
	begin
		cyc(10);
		nrst <= 1'b1;
		u_fwd.cable <= 1'b1;
		u_fwd.lock <= 1'b1;
		wb(1'b1, REG_EV_MASK, 32'h0000_003F);
		chk("hpd", 1, u_slr_link_if.hot_plug);
		rdc("lane", REG_LANE_STATE, 32'h0000_00FF, 32'h0000_0053);
		rdc("phy", REG_PHY_STATE, 32'h0000_0003, 32'h0000_0003);
		rdc("unmap", 8'h3C, 32'hFFFF_FFFF, 32'h0000_0000);
		u_fwd.video_on <= 1'b1;
		u_fwd.mode <= 8'h05;
		cyc(4);
		wb(1'b1, REG_EVENT, 32'h0000_003F);
		u_fwd.mode <= 8'h06;
		cyc(4);
		rdc("ev", REG_EVENT, 32'h0000_003F, 32'h0000_0004);
		chk("irq", 1, irq);
		chk("mode", 8'h06, stream_mode);
		u_fwd.video_on <= 1'b0;
		cyc(4);
		rdc("ev", REG_EVENT, 32'h0000_003F, 32'h0000_0005);
		chk("attr", 0, stream_attr_valid);
		u_fwd.video_on <= 1'b1;
		cyc(4);
		rdc("ev", REG_EVENT, 32'h0000_003F, 32'h0000_0007);
		chk("attr", 1, stream_attr_valid);
		wb(1'b1, REG_EVENT, 32'h0000_003F);
		rdc("ev", REG_EVENT, 32'h0000_003F, 32'h0000_0000);
		chk("irq", 0, irq);
		u_fwd.vid_valid <= 1'b1;
		u_fwd.pix <= {4{48'h1234_5678_9ABC}};
		wb(1'b1, REG_LINK_CTRL, 32'h0000_0001);
		u_fwd.pattern <= 2'h1;
		cyc(4);
		chk("vvalid", 0, vid_valid);
		rdc("tdone", REG_EVENT, 32'h0000_0040, 32'h0000_0040);
		for (int p = 0; p < 3; p++)
		begin
			wb(1'b1, REG_LINK_CTRL, 32'(p) << CTRL_PPC_LSB);
			cyc(3);
			chk("vvalid", 1, vid_valid);
			chk("pix_en", p == 0 ? PIX_EN_1 : p == 1 ? PIX_EN_2 : PIX_EN_4, 32'(vid_pix_en));
			chk("pix", 32'h5678_9ABC, vid_pixel[31:0]);
		end
		n0 = mn_cnt;
		u_fwd.vid_m <= 24'h01_2345;
		u_fwd.vid_n <= 24'h08_0000;
		u_fwd.aud_m <= 24'h00_0ABC;
		u_fwd.aud_n <= 24'h00_8000;
		cyc(4);
		chk("aud_n", 24'h00_8000, audio_n_value);
		chk("vid_m", 24'h01_2345, vid_m_value);
		chk("upd", n0 + 1, mn_cnt);
		rdc("vid_n", REG_VID_N, 32'hFFFF_FFFF, 32'h0008_0000);
		chk("aud_m", 24'h00_0ABC, audio_m_value);
		rdc("aud_m", REG_AUD_M, 32'hFFFF_FFFF, 32'h0000_0ABC);
		wb(1'b1, REG_AUD_CTRL, 32'h0000_0001);
		snd();
		chk("drop", 0, aq.size());
		pkt(1'b0, 32'h000A_0500);
		rdc("stat", REG_AUD_STATUS, 32'h0000_0003, 32'h0000_0001);
		rdc("ev", REG_EVENT, 32'h0000_0010, 32'h0000_0010);
		chk("irq", 1, irq);
		pkt(1'b0, 32'h000B_FF00);
		pkt(1'b1, 32'h0000_0E00);
		rdc("stat", REG_AUD_STATUS, 32'h0000_0003, 32'h0000_0003);
		rdc("ev", REG_EVENT, 32'h0000_0020, 32'h0000_0020);
		snd();
		chk("n", 2, aq.size());
		chk("s0", 32'h0000_1000, aq[0][31:0]);
		chk("tid0", 8'hA0, aq[0][39:32]);
		chk("tid1", 8'hA2, aq[1][39:32]);
		for (int i = 0; i < 16; i++)
		begin
			wb(1'b0, 8'h40 + 8'(4 * i), 32'h0000_0000);
			chk("word", (i < 8 ? 32'h000A_0500 : 32'h0000_0DF8) + 32'(i), rd);
		end
		rdc("stat", REG_AUD_STATUS, 32'h0000_0003, 32'h0000_0000);
		wb(1'b1, REG_EV_MASK, 32'h0000_0000);
		chk("irq", 0, irq);
		wb(1'b1, REG_AUD_CTRL, 32'h0000_0000);
		snd();
		chk("off", 0, aq.size());
		u_fwd.lock <= 1'b0;
		cyc(4);
		rdc("ev", REG_EVENT, 32'h0000_0008, 32'h0000_0008);
		u_fwd.lock <= 1'b1;
		wait (u_slr_link_if.hot_plug === 1'b0);
		n0 = rr_cnt;
		wb(1'b1, REG_HOT_PLUG, 32'h0000_0001);
		cyc(4);
		chk("hpd", 1, u_slr_link_if.hot_plug);
		chk("retrain", n0 + 1, rr_cnt);
		wait (u_slr_link_if.hot_plug === 1'b0);
		u_fwd.cable <= 1'b0;
		cyc(4);
		chk("vvalid", 0, vid_valid);
		u_fwd.cable <= 1'b1;
		cyc(4);
		chk("hpd", 1, u_slr_link_if.hot_plug);
		wait (u_slr_link_if.hot_plug === 1'b0);
		cyc(2);
		conclude();
	end
endmodule : test_sink_link_events_audio_rx
`default_nettype wire
